// ==== src/rtam_pkg.sv ====
// package for the alarm-match and interrupt block
package rtam_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_ALM_SEC   = 8'h00;
    localparam logic [7:0] ADDR_ALM_MIN   = 8'h04;
    localparam logic [7:0] ADDR_ALM_HOUR  = 8'h08;
    localparam logic [7:0] ADDR_ALM_DATE  = 8'h0C;
    localparam logic [7:0] ADDR_ALM_MONTH = 8'h10;
    localparam logic [7:0] ADDR_ALM_WDAY  = 8'h14;
    localparam logic [7:0] ADDR_INT_CTRL  = 8'h18;
    localparam logic [7:0] ADDR_STATUS    = 8'h1C;
    localparam logic [7:0] ADDR_PWR_CTRL  = 8'h20;
    // field positions
    localparam int ALM_EN_BIT     = 7;
    localparam int INT_ALM_EN_BIT = 5;
    localparam int INT_REPEAT_BIT = 7;
    localparam int STAT_FLAG_BIT  = 0;
    localparam int PWR_LEGACY_BIT = 0;
    localparam int PWR_SBI_BIT    = 1;
    // reset values
    localparam logic [7:0] ALM_RST      = 8'h00;
    localparam logic [7:0] INT_CTRL_RST = 8'h00;
    localparam logic [1:0] PWR_RST      = 2'h0;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // repeat-mode pulse length
    localparam int PULSE_NS     = 500;
    localparam int CLK_NS       = 50;
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic [7:0] wday;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rtam_time_s;
endpackage : rtam_pkg

// ==== src/rtam_top.sv ====
// alarm-match, interrupt and backup-mode logic with axi4-lite registers
`timescale 1ns/10ps
// Operation
// - each alarm field: bit 7 enables, low bits hold BCD match value
// - a field with enable clear matches any time value
// - alarm evaluated on each new second tick
// - all enabled fields match: set alarm0_flag, pull irq_freq_out low
// - alarm0_enable at control bit 5 gates every match
// - repeat_pulse_select 0 gives a single event
// - repeat_pulse_select 1 gives a pulse on every match
// - repeat_pulse_select sits at bit 7 of interrupt control
// - repeat mode sets flag each trigger, pulses never need flag clear
// - reset selects standard mode; battery switchover keeps the selected mode
// - standard mode on backup: only timekeeping runs
// - legacy on backup: alarms run; bus works unless serial_bus_inhibit set
module rtam_top
    import rtam_pkg::*;
#(
    parameter int PULSE_LEN = PULSE_CYCLES
)(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        sec_tick_i,
    input  wire rtam_time_s  time_i,
    input  wire logic        on_backup_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic             irq_freq_out_o,
    output logic             irq_freq_out_oe_o,
    output logic             functions_off_o
);
    rtam_time_s  alarm_r;
    logic [7:0]  int_ctrl_r;
    logic [1:0]  pwr_ctrl_r;
    logic        alarm0_flag_r;
    logic        irq_low_r;
    logic [7:0]  pulse_cnt_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;

    function automatic logic field_match(input logic [7:0] alm, input logic [7:0] cur);
        field_match = !alm[ALM_EN_BIT] || (alm[6:0] == cur[6:0]);
    endfunction : field_match

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a <= ADDR_PWR_CTRL) && (a[1:0] == 2'h0);
    endfunction : addr_known

    logic legacy;
    logic serial_bus_inhibit;
    logic standard_backup;
    logic bus_blocked;
    logic all_match;
    logic alarm_hit;
    logic repeat_mode;
    logic alm_en;
    assign legacy          = pwr_ctrl_r[PWR_LEGACY_BIT];
    assign serial_bus_inhibit             = pwr_ctrl_r[PWR_SBI_BIT];
    assign standard_backup = on_backup_i && !legacy;
    assign bus_blocked     = on_backup_i && (!legacy || serial_bus_inhibit);
    assign functions_off_o = standard_backup;
    assign repeat_mode     = int_ctrl_r[INT_REPEAT_BIT];
    assign alm_en          = int_ctrl_r[INT_ALM_EN_BIT];
    assign all_match = field_match(alarm_r.sec, time_i.sec) && field_match(alarm_r.min, time_i.min)
                    && field_match(alarm_r.hour, time_i.hour) && field_match(alarm_r.date, time_i.date)
                    && field_match(alarm_r.month, time_i.month) && field_match(alarm_r.wday, time_i.wday);
    assign alarm_hit = sec_tick_i && all_match && alm_en && !standard_backup;

    // write channel
    logic do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o && !bus_blocked;
    assign s_axi_wready_o  = !w_held_r && !s_axi_bvalid_o && !bus_blocked;
    assign wr_addr  = aw_held_r ? aw_addr_r : s_axi_awaddr_i;
    assign wr_data  = w_held_r ? w_data_r : s_axi_wdata_i;
    assign wr_strb  = w_held_r ? w_strb_r : s_axi_wstrb_i;
    assign do_write = (aw_held_r || (s_axi_awvalid_i && s_axi_awready_o))
                   && (w_held_r || (s_axi_wvalid_i && s_axi_wready_o));

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end
        else
        begin
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
            end
            else
            begin
                if (s_axi_awvalid_i && s_axi_awready_o)
                begin
                    aw_held_r <= 1'b1;
                    aw_addr_r <= s_axi_awaddr_i;
                end
                if (s_axi_wvalid_i && s_axi_wready_o)
                begin
                    w_held_r <= 1'b1;
                    w_data_r <= s_axi_wdata_i;
                    w_strb_r <= s_axi_wstrb_i;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= addr_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready_i)
        begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    logic wr_lane0;
    assign wr_lane0 = do_write && wr_strb[0];

    // alarm field, interrupt control and power control registers
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            alarm_r    <= {6{ALM_RST}};
            int_ctrl_r <= INT_CTRL_RST;
            pwr_ctrl_r <= PWR_RST;
        end
        else if (wr_lane0)
        begin
            case (wr_addr)
                ADDR_ALM_SEC:   alarm_r.sec   <= wr_data[7:0];
                ADDR_ALM_MIN:   alarm_r.min   <= wr_data[7:0];
                ADDR_ALM_HOUR:  alarm_r.hour  <= wr_data[7:0];
                ADDR_ALM_DATE:  alarm_r.date  <= wr_data[7:0];
                ADDR_ALM_MONTH: alarm_r.month <= wr_data[7:0];
                ADDR_ALM_WDAY:  alarm_r.wday  <= wr_data[7:0];
                ADDR_INT_CTRL:  int_ctrl_r    <= wr_data[7:0];
                ADDR_PWR_CTRL:  pwr_ctrl_r    <= wr_data[1:0];
                default:        ;
            endcase
        end
    end

    // flag: write one to clear, a new hit wins
    logic flag_clear;
    assign flag_clear = wr_lane0 && (wr_addr == ADDR_STATUS) && wr_data[STAT_FLAG_BIT];

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            alarm0_flag_r <= 1'b0;
        else if (alarm_hit)
            alarm0_flag_r <= 1'b1;
        else if (flag_clear)
            alarm0_flag_r <= 1'b0;
    end

    // pin driver
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_low_r   <= 1'b0;
            pulse_cnt_r <= 8'h00;
        end
        else if (repeat_mode)
        begin
            if (alarm_hit)
            begin
                irq_low_r   <= 1'b1;
                pulse_cnt_r <= 8'(PULSE_LEN - 1);
            end
            else if (pulse_cnt_r != 8'h00)
                pulse_cnt_r <= pulse_cnt_r - 8'h01;
            else
                irq_low_r <= 1'b0;
        end
        else
        begin
            pulse_cnt_r <= 8'h00;
            if (alarm_hit)
                irq_low_r <= 1'b1;
            else if (flag_clear || !alarm0_flag_r)
                irq_low_r <= 1'b0;
        end
    end

    // assertion helper: cycles the pin has stood low since a repeat-mode hit
    logic [7:0] low_len_r;
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            low_len_r <= 8'h00;
        else if (repeat_mode && alarm_hit)
            low_len_r <= 8'h01;
        else if (repeat_mode && irq_low_r && low_len_r != 8'h00 && low_len_r != 8'hFF)
            low_len_r <= low_len_r + 8'h01;
        else
            low_len_r <= 8'h00;
    end

    assign irq_freq_out_o    = 1'b0;
    assign irq_freq_out_oe_o = irq_low_r;

    // read channel
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (s_axi_araddr_i)
            ADDR_ALM_SEC:   rd_val[7:0] = alarm_r.sec;
            ADDR_ALM_MIN:   rd_val[7:0] = alarm_r.min;
            ADDR_ALM_HOUR:  rd_val[7:0] = alarm_r.hour;
            ADDR_ALM_DATE:  rd_val[7:0] = alarm_r.date;
            ADDR_ALM_MONTH: rd_val[7:0] = alarm_r.month;
            ADDR_ALM_WDAY:  rd_val[7:0] = alarm_r.wday;
            ADDR_INT_CTRL:  rd_val[7:0] = int_ctrl_r;
            ADDR_STATUS:    rd_val[STAT_FLAG_BIT] = alarm0_flag_r;
            ADDR_PWR_CTRL:  rd_val[1:0] = pwr_ctrl_r;
            default:        rd_val = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready_o = !s_axi_rvalid_o && !bus_blocked;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= RESP_OKAY;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_val;
            s_axi_rresp_o  <= addr_known(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // checks
    chk_hit_sets_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        alarm_hit |=> alarm0_flag_r && irq_freq_out_oe_o)
        else $error("alarm hit did not set flag and pin");
    chk_no_enable_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !alm_en |=> !$rose(alarm0_flag_r) && !$rose(irq_freq_out_oe_o))
        else $error("alarm fired while disabled");
    chk_tick_needed: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !sec_tick_i |=> !$rose(alarm0_flag_r) && !$rose(irq_freq_out_oe_o))
        else $error("alarm fired off a second tick");
    chk_single_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!repeat_mode && irq_low_r && alarm0_flag_r && !flag_clear) |=> irq_low_r)
        else $error("single event pin released early");
    sequence seq_single_clear;
        !repeat_mode && !alarm_hit && flag_clear;
    endsequence
    chk_single_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        seq_single_clear |=> !irq_low_r && !alarm0_flag_r)
        else $error("pin not released on flag clear");
    chk_clear_drops: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (flag_clear && !alarm_hit) |=> !alarm0_flag_r)
        else $error("flag not cleared");
    sequence seq_pulse_start;
        repeat_mode && alarm_hit;
    endsequence
    chk_pulse_ends: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (repeat_mode && !alarm_hit && irq_low_r && low_len_r == PULSE_LEN) |=> !irq_low_r)
        else $error("repeat pulse did not end");
    chk_pulse_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (repeat_mode && !alarm_hit && low_len_r != 8'h00 && low_len_r < PULSE_LEN) |=> irq_low_r)
        else $error("repeat pulse ended early");
    chk_repeat_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        seq_pulse_start |=> alarm0_flag_r && irq_low_r)
        else $error("repeat trigger missed");
    chk_backup_std: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (on_backup_i && !pwr_ctrl_r[PWR_LEGACY_BIT]) |-> (functions_off_o && !s_axi_arready_o
         && !s_axi_awready_o && !s_axi_wready_o) ##1 !$rose(alarm0_flag_r))
        else $error("function active in standard backup");
    chk_legacy_inhibit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (on_backup_i && pwr_ctrl_r[PWR_SBI_BIT]) |-> !s_axi_arready_o && !s_axi_awready_o && !s_axi_wready_o)
        else $error("bus open while inhibited");
    sequence seq_legacy_hit;
        on_backup_i && pwr_ctrl_r[PWR_LEGACY_BIT] && sec_tick_i && all_match && alm_en;
    endsequence
    chk_legacy_alarm: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        seq_legacy_hit |=> alarm0_flag_r && irq_freq_out_oe_o)
        else $error("legacy backup alarm missed");
    chk_field_match: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (alarm_r.min[ALM_EN_BIT] && alarm_r.min[6:0] != time_i.min[6:0]) |-> !all_match)
        else $error("enabled field mismatch ignored");
    // bad addresses answer with an error and no data
    chk_write_error: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (do_write && !addr_known(wr_addr)) |=> s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR)
        else $error("bad write address not refused");
    chk_read_error: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_axi_arvalid_i && s_axi_arready_o && !addr_known(s_axi_araddr_i))
        |=> s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
        else $error("bad read address not refused");
    chk_field_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!alarm_r.sec[ALM_EN_BIT] && !alarm_r.min[ALM_EN_BIT] && !alarm_r.hour[ALM_EN_BIT]
         && !alarm_r.date[ALM_EN_BIT] && !alarm_r.month[ALM_EN_BIT] && !alarm_r.wday[ALM_EN_BIT]) |-> all_match)
        else $error("disabled fields blocked match");
endmodule : rtam_top

// ==== tb/rtam_host_line.sv ====
// host-side model: pulled-up open-drain interrupt line and falling-edge counter
`timescale 1ns/10ps
module rtam_host_line (
    input  wire logic clk_i,
    input  wire logic oe_i,
    input  wire logic data_i,
    output logic      line_o,
    output int        falls_o
);
    logic line_d;
    // released pin floats up to the pull-up
    assign line_o = oe_i ? data_i : 1'b1;
    initial falls_o = 0;
    always @(posedge clk_i)
    begin
        line_d <= line_o;
        if (line_d === 1'b1 && line_o === 1'b0)
            falls_o <= falls_o + 1;
    end
endmodule : rtam_host_line

// ==== tb/tb_rtc_alarm_match_interrupt.sv ====
// self-checking bench for the alarm-match and interrupt block
`timescale 1ns/10ps
module tb_rtc_alarm_match_interrupt;
    import rtam_pkg::*;
    localparam int PL = 10;
    logic        clk_i = 0, arst_n_i = 0, tick = 0, bkp = 0;
    rtam_time_s  tm = '{8'h00, 8'h01, 8'h01, 8'h11, 8'h00, 8'h00};
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic        awrdy, wrdy, bvalid, arrdy, rvalid, irq_d, irq_oe, foff, line;
    logic [1:0]  bresp, rresp, r;
    int          falls, f0, n, w, n_fail = 0, compares = 0, cyc = 0;

    rtam_top #(.PULSE_LEN(PL)) DUT (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sec_tick_i(tick), .time_i(tm), .on_backup_i(bkp),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .irq_freq_out_o(irq_d), .irq_freq_out_oe_o(irq_oe), .functions_off_o(foff)
    );
    rtam_host_line host (.clk_i(clk_i), .oe_i(irq_oe), .data_i(irq_d), .line_o(line), .falls_o(falls));

    initial forever #25 clk_i = ~clk_i;

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] dv);
        logic ad, wd;
        logic [1:0] eb;
        ad = 0;
        wd = 0;
        eb = (a > ADDR_PWR_CTRL || a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
        @(posedge clk_i);
        awaddr <= a;
        wdata  <= dv;
        awv    <= 1;
        wv     <= 1;
        bready <= 1;
        while (!(ad && wd))
        begin
            @(negedge clk_i);
            if (awrdy && !ad) ad = 1;
            if (wrdy && !wd) wd = 1;
            @(posedge clk_i);
            if (ad) awv <= 0;
            if (wd) wv <= 0;
        end
        while (bvalid !== 1'b1) @(negedge clk_i);
        chk("bresp", eb, bresp);
        @(posedge clk_i);
        bready <= 0;
    endtask : wr

    task rd(input logic [7:0] a);
        w = 0;
        @(posedge clk_i);
        araddr <= a;
        arv    <= 1;
        rready <= 1;
        @(negedge clk_i);
        while (arrdy !== 1'b1)
        begin
            w++;
            @(negedge clk_i);
        end
        @(posedge clk_i);
        arv <= 0;
        while (rvalid !== 1'b1) @(negedge clk_i);
        d = rdata;
        r = rresp;
        @(posedge clk_i);
        rready <= 0;
    endtask : rd

    task tk(input logic [7:0] s, input logic [7:0] m);
        @(posedge clk_i);
        tm.sec <= s;
        tm.min <= m;
        tick   <= 1;
        @(posedge clk_i);
        tick <= 0;
        @(negedge clk_i);
    endtask : tk

    task t_reset;
        wr(8'h01, 32'h0000_00FF);
        for (int i = 0; i < 9; i++)
        begin
            rd(8'(i * 4));
            chk("reset value", 32'h0000_0000, d);
            chk("rresp", RESP_OKAY, r);
        end
        rd(8'h40);
        chk("unmapped resp", RESP_SLVERR, r);
        chk("idle line", 1'b1, line);
        $display("t_reset done");
    endtask : t_reset

    task t_single;
        wr(ADDR_ALM_MIN, 32'h0000_00B0);
        wr(ADDR_ALM_HOUR, 32'h0000_0091);
        wr(ADDR_ALM_DATE, 32'h0000_0081);
        wr(ADDR_ALM_MONTH, 32'h0000_0081);
        wr(ADDR_INT_CTRL, 32'h0000_0020);
        f0 = falls;
        tk(8'h59, 8'h29);
        chk("line before rollover", 1'b1, line);
        tk(8'h00, 8'h30);
        chk("line on match", 1'b0, line);
        rd(ADDR_STATUS);
        chk("flag on match", 32'h0000_0001, d);
        tk(8'h01, 8'h31);
        chk("line held", 1'b0, line);
        chk("single falls", 1, falls - f0);
        wr(ADDR_STATUS, 32'h0000_0001);
        @(negedge clk_i);
        chk("line after clear", 1'b1, line);
        tk(8'h00, 8'h31);
        chk("minute mismatch", 1'b1, line);
        tk(8'h07, 8'h30);
        chk("seconds ignored", 1'b0, line);
        wr(ADDR_STATUS, 32'h0000_0001);
        wr(ADDR_INT_CTRL, 32'h0000_0000);
        tk(8'h00, 8'h30);
        rd(ADDR_STATUS);
        chk("gated flag", 32'h0000_0000, d);
        chk("gated line", 1'b1, line);
        $display("t_single done");
    endtask : t_single

    task t_repeat;
        wr(ADDR_ALM_SEC, 32'h0000_00B0);
        wr(ADDR_ALM_MIN, 32'h0000_0000);
        wr(ADDR_ALM_HOUR, 32'h0000_0000);
        wr(ADDR_ALM_DATE, 32'h0000_0000);
        wr(ADDR_ALM_MONTH, 32'h0000_0000);
        wr(ADDR_INT_CTRL, 32'h0000_00A0);
        rd(ADDR_INT_CTRL);
        chk("int control", 32'h0000_00A0, d);
        f0 = falls;
        for (int m = 0; m < 2; m++)
        begin
            tk(8'h30, 8'(m));
            for (n = 1; n < 50; n++)
            begin
                @(negedge clk_i);
                if (line !== 1'b0) break;
            end
            chk("pulse length", PL, n);
            tk(8'h31, 8'(m));
            chk("no pulse off match", 1'b1, line);
        end
        chk("pulse count", 2, falls - f0);
        rd(ADDR_STATUS);
        chk("repeat flag", 32'h0000_0001, d);
        $display("t_repeat done");
    endtask : t_repeat

    task t_backup;
        @(posedge clk_i);
        bkp <= 1;
        tk(8'h30, 8'h02);
        chk("standard off", 1'b1, foff);
        chk("standard no alarm", 1'b1, line);
        @(posedge clk_i);
        bkp <= 0;
        wr(ADDR_PWR_CTRL, 32'h0000_0001);
        @(posedge clk_i);
        bkp <= 1;
        tk(8'h30, 8'h03);
        chk("legacy on", 1'b0, foff);
        chk("legacy alarm", 1'b0, line);
        rd(ADDR_PWR_CTRL);
        chk("legacy bus", 32'h0000_0001, d);
        wr(ADDR_PWR_CTRL, 32'h0000_0003);
        fork
            rd(ADDR_PWR_CTRL);
            begin
                repeat (8) @(posedge clk_i);
                bkp <= 0;
            end
        join
        chk("inhibit stall", 1'b1, w >= 7);
        chk("inhibit data", 32'h0000_0003, d);
        @(posedge clk_i);
        arst_n_i <= 0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1;
        rd(ADDR_PWR_CTRL);
        chk("pwr after reset", 32'h0000_0000, d);
        $display("t_backup done");
    endtask : t_backup

    task print_verdict;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            print_verdict;
        end
    end

    initial
    begin
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1;
        t_reset;
        t_single;
        t_repeat;
        t_backup;
        print_verdict;
    end
endmodule : tb_rtc_alarm_match_interrupt
